// *** hw/call_mode_params.svh ***
// Constants for the call-stack mode control block
`ifndef CALL_MODE_PARAMS_SVH
`define CALL_MODE_PARAMS_SVH

// ******************************************
// Register offsets (byte addresses)
// ******************************************
`define CM_OFS_STACK_BANK_SELECT 8'h00
`define CM_OFS_STATUS            8'h04

// ******************************************
// Field positions and reset values
// ******************************************
`define CM_LEGACY_MODE_BIT 3
`define CM_STACK_BANK_BIT  0
`define CM_SBS_RESET       4'h8
`define CM_ST_RUNNING_BIT  0
`define CM_ST_LEGACY_BIT   1
`define CM_ST_BANK_BIT     2

// ******************************************
// Stack bytes per call
// ******************************************
`define CM_PUSH_LEGACY   2'h2
`define CM_PUSH_EXTENDED 2'h3

// ******************************************
// Machine cycles per instruction
// ******************************************
`define CM_CYC_ABS_LEGACY     3'h3
`define CM_CYC_ABS_EXTENDED   3'h4
`define CM_CYC_SHORT_LEGACY   3'h2
`define CM_CYC_SHORT_EXTENDED 3'h3
`define CM_CYC_EXT_JUMP       3'h3
`define CM_CYC_EXT_CALL       3'h4
`define CM_CYC_PAGE_JUMP      3'h3

// ******************************************
// Oscillation settling wait
// ******************************************
`define CM_SETTLE_OSC_PERIODS 32768
`define CM_CLK_HZ             100000000
`define CM_MAIN_OSC_HZ        100000000

`endif

// *** hw/call_mode_pkg.sv ***
// Types shared by the call-stack mode control block
package call_mode_pkg;

  // Instruction classes presented by the core
  typedef enum logic [2:0] {
    OP_NONE       = 3'h0,
    OP_CALL_ABS   = 3'h1,
    OP_CALL_SHORT = 3'h2,
    OP_EXT_JUMP   = 3'h3,
    OP_EXT_CALL   = 3'h4,
    OP_PAGE_A     = 3'h5,
    OP_PAGE_B     = 3'h6
  } op_kind_e;

  // Settling sequencer states
  typedef enum logic {
    ST_SETTLE = 1'b0,
    ST_RUN    = 1'b1
  } settle_e;

endpackage

// *** hw/settle_timer.sv ***
// Fixed oscillation-settling wait after reset
`timescale 1ns/1ps
`include "call_mode_params.svh"

module settle_timer
  import call_mode_pkg::*;
#(
  parameter int unsigned CYCLES = `CM_SETTLE_OSC_PERIODS
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Status
  output logic      running_o
);

  settle_e     state_ff;
  settle_e     nxt_state;
  logic [31:0] count_ff;
  logic [31:0] nxt_count;

  // ******************************************
  // Wait sequence
  // ******************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    unique case (state_ff)
      ST_SETTLE: begin
        if (count_ff == CYCLES - 1) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_count = count_ff + 32'h1;
        end
      end
      ST_RUN: begin
        nxt_count = count_ff;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_SETTLE;
      count_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
    end
  end

  assign running_o = (state_ff == ST_RUN);

endmodule // settle_timer

// *** hw/call_timing_decode.sv ***
// Mode-dependent timing, stack use and target decode
`timescale 1ns/1ps
`include "call_mode_params.svh"

module call_timing_decode
  import call_mode_pkg::*;
(
  // Request
  input  wire logic       legacy_i,
  input  wire op_kind_e   kind_i,
  input  wire logic [13:0] pc_i,
  input  wire logic [7:0] pair_i,
  // Result
  output logic [2:0]      cycles_o,
  output logic [1:0]      push_o,
  output logic            illegal_o,
  output logic [13:0]     pc_o
);

  function automatic logic [1:0] push_bytes(input logic legacy);
    return legacy ? `CM_PUSH_LEGACY : `CM_PUSH_EXTENDED;
  endfunction

  function automatic logic [13:0] page_target(input logic [13:0] pc,
                                              input logic [7:0]  low);
    return {pc[13:8], low};
  endfunction

  always_comb begin
    cycles_o  = 3'h0;
    push_o    = 2'h0;
    illegal_o = 1'b0;
    pc_o      = pc_i;
    unique case (kind_i)
      OP_CALL_ABS: begin
        cycles_o = legacy_i ? `CM_CYC_ABS_LEGACY : `CM_CYC_ABS_EXTENDED;
        push_o   = push_bytes(legacy_i);
      end
      OP_CALL_SHORT: begin
        cycles_o = legacy_i ? `CM_CYC_SHORT_LEGACY
                            : `CM_CYC_SHORT_EXTENDED;
        push_o   = push_bytes(legacy_i);
      end
      OP_EXT_JUMP: begin
        illegal_o = legacy_i;
        cycles_o  = legacy_i ? 3'h0 : `CM_CYC_EXT_JUMP;
      end
      OP_EXT_CALL: begin
        illegal_o = legacy_i;
        cycles_o  = legacy_i ? 3'h0 : `CM_CYC_EXT_CALL;
        push_o    = legacy_i ? 2'h0 : push_bytes(legacy_i);
      end
      OP_PAGE_A: begin
        cycles_o = `CM_CYC_PAGE_JUMP;
        pc_o     = page_target(pc_i, pair_i);
      end
      OP_PAGE_B: begin
        cycles_o = `CM_CYC_PAGE_JUMP;
        pc_o     = page_target(pc_i, pair_i);
      end
      default: begin
        cycles_o = 3'h0;
      end
    endcase
  end

endmodule // call_timing_decode

// *** hw/call_stack_mode_control.sv ***
// Call-stack mode control with Wishbone register access
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "call_mode_params.svh"

module call_stack_mode_control
  import call_mode_pkg::*;
#(
  parameter longint unsigned CLK_HZ      = `CM_CLK_HZ,
  parameter longint unsigned MAIN_OSC_HZ = `CM_MAIN_OSC_HZ,
  parameter int unsigned     SETTLE_CYCLES =
    int'((64'(`CM_SETTLE_OSC_PERIODS) * CLK_HZ + MAIN_OSC_HZ - 64'd1)
         / MAIN_OSC_HZ)
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Instruction request from core
  input  wire logic        op_valid_i,
  input  wire op_kind_e    op_kind_i,
  input  wire logic [13:0] op_pc_i,
  input  wire logic [7:0]  op_pair_i,
  // Instruction result
  output logic             op_done_o,
  output logic             op_illegal_o,
  output logic      [2:0]  op_cycles_o,
  output logic      [1:0]  op_push_o,
  output logic      [13:0] op_pc_o,
  // Mode status
  output logic             legacy_mode_o,
  output logic             stack_bank_o,
  output logic             running_o
);

  // ******************************************
  // Declarations
  // ******************************************
  logic [3:0]  sbs_ff;
  logic [3:0]  nxt_sbs;
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic        done_ff;
  logic        nxt_done;
  logic        illegal_ff;
  logic        nxt_illegal;
  logic [2:0]  cycles_ff;
  logic [2:0]  nxt_cycles;
  logic [1:0]  push_ff;
  logic [1:0]  nxt_push;
  logic [13:0] pc_ff;
  logic [13:0] nxt_pc;
  logic        legacy_ff;
  logic        bank_ff;
  logic        run_ff;
  logic        running;
  logic        bus_req;
  logic        dec_illegal;
  logic [2:0]  dec_cycles;
  logic [1:0]  dec_push;
  logic [13:0] dec_pc;

  // ******************************************
  // Settling wait
  // ******************************************
  settle_timer #(
    .CYCLES    (SETTLE_CYCLES)
  ) u_settle (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .running_o (running)
  );

  // ******************************************
  // Mode-dependent decode
  // ******************************************
  call_timing_decode u_decode (
    .legacy_i  (sbs_ff[`CM_LEGACY_MODE_BIT]),
    .kind_i    (op_kind_i),
    .pc_i      (op_pc_i),
    .pair_i    (op_pair_i),
    .cycles_o  (dec_cycles),
    .push_o    (dec_push),
    .illegal_o (dec_illegal),
    .pc_o      (dec_pc)
  );

  // ******************************************
  // Register bus
  // ******************************************
  assign bus_req = cyc_i && stb_i && !ack_ff;

  always_comb begin
    nxt_sbs  = sbs_ff;
    nxt_ack  = bus_req;
    nxt_rdat = 32'h0;
    if (bus_req && we_i && sel_i[0] &&
        adr_i == `CM_OFS_STACK_BANK_SELECT) begin
      nxt_sbs = dat_i[3:0];
    end
    if (bus_req && !we_i) begin
      unique case (adr_i)
        `CM_OFS_STACK_BANK_SELECT: begin
          nxt_rdat = {28'h0, sbs_ff};
        end
        `CM_OFS_STATUS: begin
          nxt_rdat[`CM_ST_RUNNING_BIT] = running;
          nxt_rdat[`CM_ST_LEGACY_BIT]  = sbs_ff[`CM_LEGACY_MODE_BIT];
          nxt_rdat[`CM_ST_BANK_BIT]    = sbs_ff[`CM_STACK_BANK_BIT];
        end
        default: begin
          nxt_rdat = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sbs_ff  <= `CM_SBS_RESET;
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      sbs_ff  <= nxt_sbs;
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // ******************************************
  // Instruction results
  // ******************************************
  always_comb begin
    nxt_done    = 1'b0;
    nxt_illegal = illegal_ff;
    nxt_cycles  = cycles_ff;
    nxt_push    = push_ff;
    nxt_pc      = pc_ff;
    if (op_valid_i && running && op_kind_i != OP_NONE) begin
      nxt_done    = 1'b1;
      nxt_illegal = dec_illegal;
      nxt_cycles  = dec_cycles;
      nxt_push    = dec_push;
      nxt_pc      = dec_pc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff    <= 1'b0;
      illegal_ff <= 1'b0;
      cycles_ff  <= 3'h0;
      push_ff    <= 2'h0;
      pc_ff      <= 14'h0;
      legacy_ff  <= 1'b1;
      bank_ff    <= 1'b0;
      run_ff     <= 1'b0;
    end else begin
      done_ff    <= nxt_done;
      illegal_ff <= nxt_illegal;
      cycles_ff  <= nxt_cycles;
      push_ff    <= nxt_push;
      pc_ff      <= nxt_pc;
      legacy_ff  <= sbs_ff[`CM_LEGACY_MODE_BIT];
      bank_ff    <= sbs_ff[`CM_STACK_BANK_BIT];
      run_ff     <= running;
    end
  end

  assign dat_o         = rdat_ff;
  assign ack_o         = ack_ff;
  assign op_done_o     = done_ff;
  assign op_illegal_o  = illegal_ff;
  assign op_cycles_o   = cycles_ff;
  assign op_push_o     = push_ff;
  assign op_pc_o       = pc_ff;
  assign legacy_mode_o = legacy_ff;
  assign stack_bank_o  = bank_ff;
  assign running_o     = run_ff;

  // ******************************************
  // Assertions
  // ******************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_op_taken(op_kind_e k);
    op_valid_i && running && op_kind_i == k;
  endsequence

  sequence s_mode_write(logic v);
    bus_req && we_i && sel_i[0] &&
    adr_i == `CM_OFS_STACK_BANK_SELECT && dat_i[3] == v;
  endsequence

  property p_mode_follows_bit;
    s_mode_write(1'b0) |-> ##2 !legacy_mode_o;
  endproperty
  a_mode_follows_bit: assert property (p_mode_follows_bit)
    else $error("mode output did not follow cleared mode bit");

  property p_push_bytes;
    (s_op_taken(OP_CALL_ABS) or s_op_taken(OP_CALL_SHORT)) |=>
      op_push_o == ($past(sbs_ff[3]) ? 2'h2 : 2'h3);
  endproperty
  a_push_bytes: assert property (p_push_bytes)
    else $error("call pushed wrong byte count");

  property p_ext_illegal_legacy;
    (s_op_taken(OP_EXT_JUMP) or s_op_taken(OP_EXT_CALL)) |=>
      op_illegal_o == $past(sbs_ff[3]) && op_done_o;
  endproperty
  a_ext_illegal_legacy: assert property (p_ext_illegal_legacy)
    else $error("extended instruction legality wrong");

  property p_abs_cycles;
    s_op_taken(OP_CALL_ABS) |=>
      op_cycles_o == ($past(sbs_ff[3]) ? 3'h3 : 3'h4);
  endproperty
  a_abs_cycles: assert property (p_abs_cycles)
    else $error("absolute call cycle count wrong");

  property p_short_cycles;
    s_op_taken(OP_CALL_SHORT) |=>
      op_cycles_o == ($past(sbs_ff[3]) ? 3'h2 : 3'h3);
  endproperty
  a_short_cycles: assert property (p_short_cycles)
    else $error("short call cycle count wrong");

  property p_reset_legacy;
    $fell(rst_i) |-> legacy_mode_o && sbs_ff[3];
  endproperty
  a_reset_legacy: assert property (@(posedge clk_i) p_reset_legacy)
    else $error("device did not start in legacy mode");

  property p_bank_follows;
    s_mode_write(dat_i[3]) ##0 (dat_i[0] == 1'b1) |-> ##2 stack_bank_o;
  endproperty
  a_bank_follows: assert property (p_bank_follows)
    else $error("stack bank output did not follow write");

  property p_bank_clears;
    s_mode_write(dat_i[3]) ##0 (dat_i[0] == 1'b0) |-> ##2 !stack_bank_o;
  endproperty
  a_bank_clears: assert property (p_bank_clears)
    else $error("stack bank output did not follow cleared bit");

  property p_mode_sets_legacy;
    s_mode_write(1'b1) |-> ##2 legacy_mode_o;
  endproperty
  a_mode_sets_legacy: assert property (p_mode_sets_legacy)
    else $error("mode output did not follow set mode bit");

  property p_no_op_while_settling;
    !running |=> !op_done_o;
  endproperty
  a_no_op_while_settling: assert property (p_no_op_while_settling)
    else $error("instruction completed during settling wait");

  property p_page_low_bits;
    (s_op_taken(OP_PAGE_A) or s_op_taken(OP_PAGE_B)) |=>
      op_pc_o == {$past(op_pc_i[13:8]), $past(op_pair_i)};
  endproperty
  a_page_low_bits: assert property (p_page_low_bits)
    else $error("page jump changed upper PC bits");

  property p_readback;
    bus_req && !we_i && adr_i == `CM_OFS_STACK_BANK_SELECT |=>
      ack_o && dat_o == {28'h0, $past(sbs_ff)};
  endproperty
  a_readback: assert property (p_readback)
    else $error("register read did not return stored value");

  property p_ack_one_cycle;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle)
    else $error("acknowledge held longer than one cycle");

endmodule // call_stack_mode_control

// *** tb/call_stack_mode_control_bench.sv ***
// Self-checking bench for the call-stack mode control block
`timescale 1ns/1ps

module call_stack_mode_control_bench
  import call_mode_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  localparam int SETTLE = 16;
  localparam logic [13:0] PC   = 14'h2A5C;
  localparam logic [7:0]  PAIR = 8'hC3;
  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  logic        cyc_i      = 1'b0;
  logic        stb_i      = 1'b0;
  logic        we_i       = 1'b0;
  logic [7:0]  adr_i      = 8'h00;
  logic [3:0]  sel_i      = 4'h0;
  logic [31:0] dat_i      = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        op_valid_i = 1'b0;
  op_kind_e    op_kind_i  = OP_NONE;
  logic [13:0] op_pc_i    = PC;
  logic [7:0]  op_pair_i  = PAIR;
  logic        op_done_o;
  logic        op_illegal_o;
  logic [2:0]  op_cycles_o;
  logic [1:0]  op_push_o;
  logic [13:0] op_pc_o;
  logic        legacy_mode_o;
  logic        stack_bank_o;
  logic        running_o;
  logic [31:0] q;
  int          miscompares = 0;
  int          tests_run   = 0;
  int          n;

  call_stack_mode_control #(.SETTLE_CYCLES(SETTLE))
    call_stack_mode_control_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .op_valid_i(op_valid_i),
    .op_kind_i(op_kind_i), .op_pc_i(op_pc_i), .op_pair_i(op_pair_i),
    .op_done_o(op_done_o), .op_illegal_o(op_illegal_o),
    .op_cycles_o(op_cycles_o), .op_push_o(op_push_o),
    .op_pc_o(op_pc_o), .legacy_mode_o(legacy_mode_o),
    .stack_bank_o(stack_bank_o), .running_o(running_o));

  always #5 clk_i = ~clk_i;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    if (ack_o !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask

  // Issue one op and compare its result with the mode-derived figures
  task automatic op(input int k, input logic leg);
    logic [2:0]  cy;
    logic [1:0]  pu;
    logic        il;
    logic [13:0] pc;
    il = leg && (k == 3 || k == 4);
    cy = il ? 3'h0 : k == 1 ? (leg ? 3'h3 : 3'h4) :
         k == 2 ? (leg ? 3'h2 : 3'h3) : k == 4 ? 3'h4 : 3'h3;
    pu = il ? 2'h0 : (k == 1 || k == 2 || k == 4) ? (leg ? 2'h2 : 2'h3)
                                                  : 2'h0;
    pc = (k >= 5) ? {PC[13:8], PAIR} : PC;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_kind_i  <= op_kind_e'(k[2:0]);
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
    check("op_done", 32'(op_done_o), 32'h1);
    check("op_cycles", 32'(op_cycles_o), 32'(cy));
    check("op_push", 32'(op_push_o), 32'(pu));
    check("op_illegal", 32'(op_illegal_o), 32'(il));
    check("op_pc", 32'(op_pc_o), 32'(pc));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i      <= 1'b0;
    op_valid_i <= 1'b1;
    op_kind_i  <= OP_CALL_ABS;
    @(posedge clk_i);
    #1;
    check("legacy_mode", 32'(legacy_mode_o), 32'h1);
    n = 1;
    // Ops held during the settling wait must be refused
    while (running_o !== 1'b1 && n < 40) begin
      check("op_done_early", 32'(op_done_o), 32'h0);
      @(posedge clk_i);
      #1;
      n++;
    end
    check("settle_len", 32'(n >= SETTLE && n <= SETTLE + 2), 32'h1);
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    wb(1'b0, 8'h00, 4'hF, 32'h0, q);
    check("sbs_reset", q, 32'h8);
    wb(1'b0, 8'h04, 4'hF, 32'h0, q);
    check("status", q, 32'h3);
    wb(1'b0, 8'h10, 4'hF, 32'h0, q);
    check("unmapped", q, 32'h0);
    for (int k = 1; k <= 6; k++) op(k, 1'b1);
    wb(1'b1, 8'h00, 4'h1, 32'h0, q);
    @(posedge clk_i);
    #1;
    check("legacy_mode", 32'(legacy_mode_o), 32'h0);
    for (int k = 1; k <= 6; k++) op(k, 1'b0);
    wb(1'b1, 8'h00, 4'h1, 32'h6, q);
    wb(1'b0, 8'h00, 4'hF, 32'h0, q);
    check("sbs_readback", q, 32'h6);
    wb(1'b1, 8'h00, 4'h1, 32'hB, q);
    wb(1'b0, 8'h00, 4'hF, 32'h0, q);
    check("sbs_readback", q, 32'hB);
    check("stack_bank", 32'(stack_bank_o), 32'h1);
    wb(1'b1, 8'h00, 4'h0, 32'h0, q);
    wb(1'b1, 8'h04, 4'hF, 32'h0, q);
    wb(1'b0, 8'h00, 4'hF, 32'h0, q);
    check("sbs_no_lane", q, 32'hB);
    wb(1'b0, 8'h04, 4'hF, 32'h0, q);
    check("status", q, 32'h7);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 4'hF, 32'h0, q);
    check("sbs_reset", q, 32'h8);
    check("stack_bank", 32'(stack_bank_o), 32'h0);
    stop_test();
  end
endmodule // call_stack_mode_control_bench
